// ### rtl/scpi_core.sv
// select-code priority interrupt controller, top level
`timescale 1ns/100ps
`default_nettype none
`include "scpi_consts.svh"
module scpi_core (
	input  wire logic                         i_clk_sys,
	input  wire logic                         i_srst,
	input  wire logic                         i_ce,
	input  wire logic                         i_preset,
	input  wire scpi_pkg::scpi_cpu_t          i_cpu,
	input  wire scpi_pkg::scpi_io_t           i_io,
	input  wire logic [`SCPI_NCH-1:8]         i_dev_flag,
	input  wire logic                         i_pwr_fail,
	input  wire logic                         i_mux_valid,
	input  wire logic [`SCPI_SEL_W-1:0]       i_mux_code,
	input  wire logic                         i_mem_err,
	input  wire logic                         i_err_parity,
	input  wire logic [`SCPI_MAR_W-1:0]       i_err_addr,
	input  wire logic [1:0]                   i_dma_done,
	input  wire logic [7:0]                   i_reg_addr,
	input  wire logic [31:0]                  i_reg_wdata,
	input  wire logic                         i_reg_wr,
	input  wire logic                         i_reg_rd,
	output logic      [31:0]                  o_reg_rdata,
	output logic                              o_int_take,
	output logic      [`SCPI_MAR_W-1:0]       o_mar,
	output logic      [15:0]                  o_io_rdata,
	output logic      [1:0]                   o_dma_init,
	output logic                              o_req_valid,
	output logic      [`SCPI_SEL_W-1:0]       o_req_code
);
	function automatic logic [`SCPI_NCH-1:0] scpi_dec(input logic [`SCPI_SEL_W-1:0] sel);
		scpi_dec = 64'h0000000000000001 << sel;
	endfunction : scpi_dec

	function automatic logic scpi_is_op(input scpi_pkg::scpi_io_t io,
		input scpi_pkg::scpi_op_t op);
		scpi_is_op = io.valid && (io.op == op);
	endfunction : scpi_is_op

	logic [`SCPI_NCH-1:0]   flag_ff;
	logic [`SCPI_NCH-1:0]   nxt_flag;
	logic [`SCPI_NCH-1:0]   ctl_ff;
	logic [`SCPI_NCH-1:0]   nxt_ctl;
	logic                   ien_ff;
	logic                   defer_ff;
	logic [1:0]             ind_cnt_ff;
	logic [`SCPI_SEL_W-1:0] last_code_ff;
	logic                   err_parity_ff;
	logic [`SCPI_MAR_W-1:0] err_addr_ff;
	scpi_pkg::scpi_fsm_t    fsm_ff;
	scpi_pkg::scpi_fsm_t    nxt_fsm;

	logic [`SCPI_PIN_W-1:0] pins_sync;
	logic [`SCPI_NCH-1:8]   dev_flag_s;
	logic                   pwr_fail_s;
	logic                   mux_valid_s;
	logic [`SCPI_SEL_W-1:0] mux_code_s;
	logic                   preset_s;
	logic                   init_clear;
	logic [`SCPI_NCH-1:0]   sel_vec;
	logic                   sel_chan;
	logic                   iop_prio;
	logic [`SCPI_NCH-1:0]   set_vec;
	logic [`SCPI_NCH-1:0]   clr_vec;
	logic [`SCPI_NCH-1:0]   elig;
	logic                   blocked;
	logic                   dma_ok;

	// all pin inputs share one synchroniser; the mux code lines may
	// skew by a cycle, so a code is only used once the valid line agrees
	scpi_sync #(
		.W (`SCPI_PIN_W)
	) u_sync (
		.i_clk_sys (i_clk_sys),
		.i_srst    (i_srst),
		.i_ce      (i_ce),
		.i_async   ({i_preset, i_mux_code, i_mux_valid, i_pwr_fail, i_dev_flag}),
		.o_sync    (pins_sync)
	);

	assign {preset_s, mux_code_s, mux_valid_s, pwr_fail_s, dev_flag_s} = pins_sync;

	// front-panel preset is ignored while the processor runs
	assign init_clear = preset_s && !i_cpu.running;

	assign sel_vec  = scpi_dec(i_io.sel[`SCPI_SEL_W-1:0]);
	assign sel_chan = i_io.sel >= `SCPI_SC_PWRF;
	assign iop_prio = scpi_is_op(i_io, scpi_pkg::SCPI_OP_SET_CTL)
		|| scpi_is_op(i_io, scpi_pkg::SCPI_OP_CLR_CTL)
		|| scpi_is_op(i_io, scpi_pkg::SCPI_OP_SET_FLG)
		|| scpi_is_op(i_io, scpi_pkg::SCPI_OP_CLR_FLG);

	always_comb
	begin
		set_vec = '0;
		clr_vec = '0;
		set_vec[`SCPI_NCH-1:8] = dev_flag_s;
		if (mux_valid_s && mux_code_s >= `SCPI_SC_IO_FIRST)
			set_vec = set_vec | scpi_dec(mux_code_s);
		set_vec[`SCPI_SC_PWRF] = pwr_fail_s;
		set_vec[`SCPI_SC_MERR] = i_mem_err;
		set_vec[`SCPI_SC_DMA1] = i_dma_done[0];
		set_vec[`SCPI_SC_DMA2] = i_dma_done[1];
		if (scpi_is_op(i_io, scpi_pkg::SCPI_OP_SET_FLG) && sel_chan)
			set_vec = set_vec | sel_vec;
		if (scpi_is_op(i_io, scpi_pkg::SCPI_OP_CLR_FLG) && sel_chan)
			clr_vec = sel_vec;
	end

	// set beats clear so a flag arriving during its clear is kept
	assign nxt_flag = (flag_ff & ~clr_vec) | set_vec;

	always_comb
	begin
		nxt_ctl = ctl_ff;
		if (scpi_is_op(i_io, scpi_pkg::SCPI_OP_SET_CTL) && sel_chan)
			nxt_ctl = ctl_ff | sel_vec;
		else if (scpi_is_op(i_io, scpi_pkg::SCPI_OP_CLR_CTL) && sel_chan)
			nxt_ctl = ctl_ff & ~sel_vec;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			flag_ff <= `SCPI_FLAG_RST;
			ctl_ff  <= `SCPI_CTL_RST;
		end
		else if (i_ce)
		begin
			if (init_clear)
			begin
				flag_ff <= `SCPI_FLAG_RST;
				ctl_ff  <= `SCPI_CTL_RST;
			end
			else
			begin
				flag_ff <= nxt_flag;
				ctl_ff  <= nxt_ctl;
			end
		end
	end

	// global enable: instruction to code 00 takes precedence over the bus
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			ien_ff <= `SCPI_IEN_RST;
		else if (i_ce)
		begin
			if (init_clear)
				ien_ff <= `SCPI_IEN_RST;
			else if (scpi_is_op(i_io, scpi_pkg::SCPI_OP_SET_FLG) && i_io.sel == `SCPI_SC_IEN)
				ien_ff <= 1'b1;
			else if (scpi_is_op(i_io, scpi_pkg::SCPI_OP_CLR_FLG) && i_io.sel == `SCPI_SC_IEN)
				ien_ff <= 1'b0;
			else if (i_reg_wr && i_reg_addr == `SCPI_REG_CTRL)
				ien_ff <= i_reg_wdata[0];
		end
	end

	// a flag counts only with its control bit; internal codes never do
	assign elig = flag_ff & ctl_ff & ~`SCPI_INTERNAL_MASK;

	scpi_prio_net u_prio (
		.i_elig  (elig),
		.o_valid (o_req_valid),
		.o_code  (o_req_code)
	);

	// deferral lasts past the current phase end only
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			defer_ff <= 1'b0;
		else if (i_ce)
		begin
			if (iop_prio)
				defer_ff <= 1'b1;
			else if (i_cpu.phase_end)
				defer_ff <= 1'b0;
		end
	end

	assign blocked = !ien_ff
		|| i_cpu.halted || i_cpu.single_step
		|| (fsm_ff != scpi_pkg::SCPI_S_OPEN) || i_cpu.ind_jump
		|| iop_prio || defer_ff;

	assign dma_ok = !i_cpu.dma_active || (o_req_code == `SCPI_SC_PWRF);

	assign o_int_take = i_ce && i_cpu.phase_end && o_req_valid && !blocked && dma_ok;

	always_comb
	begin
		nxt_fsm = fsm_ff;
		case (fsm_ff)
			scpi_pkg::SCPI_S_OPEN:
			begin
				if (o_int_take)
					nxt_fsm = scpi_pkg::SCPI_S_VECTOR;
				else if (i_cpu.ind_jump)
					nxt_fsm = scpi_pkg::SCPI_S_INDJ;
			end
			scpi_pkg::SCPI_S_VECTOR:
			begin
				if (i_cpu.instr_done)
					nxt_fsm = scpi_pkg::SCPI_S_TAIL;
				else if (i_cpu.ind_phase && !i_cpu.ind_jump
					&& ind_cnt_ff == `SCPI_IND_PHASES - 2'h1)
					nxt_fsm = scpi_pkg::SCPI_S_OPEN;
			end
			scpi_pkg::SCPI_S_INDJ:
			begin
				if (i_cpu.instr_done)
					nxt_fsm = scpi_pkg::SCPI_S_TAIL;
			end
			scpi_pkg::SCPI_S_TAIL:
			begin
				if (i_cpu.phase_end)
					nxt_fsm = scpi_pkg::SCPI_S_OPEN;
			end
			default:
				nxt_fsm = scpi_pkg::SCPI_S_OPEN;
		endcase
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			fsm_ff <= scpi_pkg::SCPI_S_OPEN;
		else if (i_ce)
			fsm_ff <= nxt_fsm;
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			ind_cnt_ff <= 2'h0;
		else if (i_ce)
		begin
			if (fsm_ff != scpi_pkg::SCPI_S_VECTOR)
				ind_cnt_ff <= 2'h0;
			else if (i_cpu.ind_phase)
				ind_cnt_ff <= ind_cnt_ff + 2'h1;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			o_mar        <= '0;
			last_code_ff <= '0;
		end
		else if (i_ce && o_int_take)
		begin
			o_mar        <= {`SCPI_PAD_W'(0), o_req_code};
			last_code_ff <= o_req_code;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			err_parity_ff <= 1'b0;
			err_addr_ff   <= '0;
		end
		else if (i_ce && i_mem_err)
		begin
			err_parity_ff <= i_err_parity;
			err_addr_ff   <= i_err_addr;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			o_io_rdata <= 16'h0000;
		else if (i_ce)
		begin
			if (scpi_is_op(i_io, scpi_pkg::SCPI_OP_LOAD_IN) && i_io.sel == `SCPI_SC_PWRF)
				o_io_rdata <= {10'h000, last_code_ff};
			else if (scpi_is_op(i_io, scpi_pkg::SCPI_OP_LOAD_IN) && i_io.sel == `SCPI_SC_MERR)
				o_io_rdata <= {err_parity_ff, err_addr_ff};
			else
				o_io_rdata <= 16'h0000;
		end
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			o_dma_init <= 2'h0;
		else if (i_ce)
		begin
			o_dma_init[0] <= scpi_is_op(i_io, scpi_pkg::SCPI_OP_SET_CTL)
				&& i_io.sel == `SCPI_SC_DMA1_INIT;
			o_dma_init[1] <= scpi_is_op(i_io, scpi_pkg::SCPI_OP_SET_CTL)
				&& i_io.sel == `SCPI_SC_DMA2_INIT;
		end
	end

	// read data valid only in the cycle after the strobe
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			o_reg_rdata <= 32'h00000000;
		else if (i_ce)
		begin
			if (!i_reg_rd)
				o_reg_rdata <= 32'h00000000;
			else if (i_reg_addr == `SCPI_REG_CTRL)
				o_reg_rdata <= {31'h00000000, ien_ff};
			else if (i_reg_addr == `SCPI_REG_STATUS)
				o_reg_rdata <= {16'h0000, fsm_ff, last_code_ff, blocked, o_req_valid, o_req_code};
			else if (i_reg_addr == `SCPI_REG_FLAG_LO)
				o_reg_rdata <= flag_ff[31:0];
			else if (i_reg_addr == `SCPI_REG_FLAG_HI)
				o_reg_rdata <= flag_ff[63:32];
			else if (i_reg_addr == `SCPI_REG_CTL_LO)
				o_reg_rdata <= ctl_ff[31:0];
			else if (i_reg_addr == `SCPI_REG_CTL_HI)
				o_reg_rdata <= ctl_ff[63:32];
			else if (i_reg_addr == `SCPI_REG_ERR)
				o_reg_rdata <= {16'h0000, err_parity_ff, err_addr_ff};
			else
				o_reg_rdata <= 32'h00000000;
		end
	end

	a_take_phase: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		o_int_take |-> i_cpu.phase_end && o_req_valid)
		else $error("interrupt taken outside a phase end");

	a_take_enabled: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		o_int_take |-> ien_ff && ctl_ff[o_req_code] && flag_ff[o_req_code])
		else $error("interrupt taken while disabled");

	a_halt_no_take: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(i_cpu.halted || i_cpu.single_step) |-> !o_int_take)
		else $error("interrupt taken while halted or stepping");

	a_vector_load: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		o_int_take |=> o_mar == {9'h000, $past(o_req_code)})
		else $error("vector address not loaded");

	a_after_block: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		o_int_take |=> !o_int_take [*2])
		else $error("interrupt system not held after interrupt");

	a_dma_pwrf_only: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(o_int_take && i_cpu.dma_active) |-> o_req_code == 6'h04)
		else $error("non power-fail interrupt during dma");

	a_iop_defer: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(i_ce && iop_prio) |-> !o_int_take ##1 !o_int_take)
		else $error("interrupt not deferred after control or flag op");

	a_prio_lowest: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		o_req_valid |-> elig[o_req_code] && ((elig & ~(64'hFFFFFFFFFFFFFFFF << o_req_code)) == '0))
		else $error("winner is not the highest-priority request");

	a_no_req_idle: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(elig == '0) |-> !o_req_valid)
		else $error("request shown with no eligible flag");

	a_flag_sticky: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		!scpi_is_op(i_io, scpi_pkg::SCPI_OP_CLR_FLG) |=> ($past(flag_ff) & ~flag_ff) == '0)
		else $error("flag dropped without a clear");

	a_ien_cmd: assert property (@(posedge i_clk_sys) disable iff (i_srst)
		(i_ce && scpi_is_op(i_io, scpi_pkg::SCPI_OP_SET_FLG) && i_io.sel == 6'h00 && !init_clear)
		|=> ien_ff)
		else $error("set-flag to code 00 did not enable");

	a_power_up: assert property (@(posedge i_clk_sys)
		$fell(i_srst) |-> flag_ff == 64'hFFFFFFFFFFFFFFFF && ctl_ff == '0 && !ien_ff)
		else $error("power-up state wrong");

endmodule : scpi_core
`default_nettype wire

// ### rtl/scpi_consts.svh
// constants of the select-code priority interrupt block
`ifndef SCPI_CONSTS_SVH
`define SCPI_CONSTS_SVH

`define SCPI_SEL_W        6
`define SCPI_NCH          64
`define SCPI_MAR_W        15
`define SCPI_PAD_W        9
`define SCPI_PIN_W        65

`define SCPI_SC_IEN       6'h00
`define SCPI_SC_DMA1_INIT 6'h02
`define SCPI_SC_DMA2_INIT 6'h03
`define SCPI_SC_PWRF      6'h04
`define SCPI_SC_MERR      6'h05
`define SCPI_SC_DMA1      6'h06
`define SCPI_SC_DMA2      6'h07
`define SCPI_SC_IO_FIRST  6'h08

`define SCPI_INTERNAL_MASK 64'h000000000000000F
`define SCPI_FLAG_RST      64'hFFFFFFFFFFFFFFFF
`define SCPI_CTL_RST       64'h0000000000000000
`define SCPI_IEN_RST       1'h0
`define SCPI_IND_PHASES    2'h2

`define SCPI_REG_CTRL     8'h00
`define SCPI_REG_STATUS   8'h04
`define SCPI_REG_FLAG_LO  8'h08
`define SCPI_REG_FLAG_HI  8'h0C
`define SCPI_REG_CTL_LO   8'h10
`define SCPI_REG_CTL_HI   8'h14
`define SCPI_REG_ERR      8'h18

`endif

// ### rtl/scpi_pkg.sv
// types of the select-code priority interrupt block
package scpi_pkg;

	typedef enum logic [2:0] {
		SCPI_OP_NONE    = 3'h0,
		SCPI_OP_SET_CTL = 3'h1,
		SCPI_OP_CLR_CTL = 3'h2,
		SCPI_OP_SET_FLG = 3'h3,
		SCPI_OP_CLR_FLG = 3'h4,
		SCPI_OP_LOAD_IN = 3'h5
	} scpi_op_t;

	typedef enum logic [1:0] {
		SCPI_S_OPEN   = 2'h0,
		SCPI_S_VECTOR = 2'h1,
		SCPI_S_INDJ   = 2'h2,
		SCPI_S_TAIL   = 2'h3
	} scpi_fsm_t;

	typedef struct packed {
		logic     valid;
		scpi_op_t op;
		logic [5:0] sel;
	} scpi_io_t;

	typedef struct packed {
		logic phase_end;
		logic halted;
		logic single_step;
		logic running;
		logic ind_jump;
		logic ind_phase;
		logic instr_done;
		logic dma_active;
	} scpi_cpu_t;

endpackage : scpi_pkg

// ### rtl/scpi_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
`default_nettype none
module scpi_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk_sys,
	input  wire logic         i_srst,
	input  wire logic         i_ce,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
		begin
			meta_ff <= '0;
			sync_ff <= '0;
		end
		else if (i_ce)
		begin
			meta_ff <= i_async;
			sync_ff <= meta_ff;
		end
	end

	assign o_sync = sync_ff;
endmodule : scpi_sync
`default_nettype wire

// ### rtl/scpi_prio_net.sv
// priority network: lowest eligible select code wins
`timescale 1ns/100ps
`default_nettype none
`include "scpi_consts.svh"
module scpi_prio_net (
	input  wire logic [`SCPI_NCH-1:0]   i_elig,
	output logic                        o_valid,
	output logic      [`SCPI_SEL_W-1:0] o_code
);
	always_comb
	begin
		o_valid = 1'b0;
		o_code  = 6'h00;
		// scan downward so the lowest set code is the last written
		for (int i = `SCPI_NCH - 1; i >= 0; i--)
		begin
			if (i_elig[i])
			begin
				o_valid = 1'b1;
				o_code  = 6'(i);
			end
		end
	end
endmodule : scpi_prio_net
`default_nettype wire

// ### dv/scpi_dev_model.sv
// device card on one channel: flags completion after a set-control
`timescale 1ns/100ps
`default_nettype none
`include "scpi_consts.svh"
module scpi_dev_model #(
	parameter logic [5:0] CODE = 6'h09,
	parameter int         DLY  = 5
) (
	input  wire logic               i_clk_sys,
	input  wire logic               i_srst,
	input  wire scpi_pkg::scpi_io_t i_io,
	output logic [`SCPI_NCH-1:8]    o_dev_flag
);
	int         cnt_ff;
	logic [1:0] hold_ff;

	// a set-control to our code starts the operation
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			cnt_ff <= 0;
		else if (i_io.valid && i_io.op == scpi_pkg::SCPI_OP_SET_CTL && i_io.sel == CODE)
			cnt_ff <= DLY;
		else if (cnt_ff > 0)
			cnt_ff <= cnt_ff - 1;
	end

	// done line held two cycles so the synchroniser cannot miss it
	always_ff @(posedge i_clk_sys)
	begin
		if (i_srst)
			hold_ff <= 2'h0;
		else if (cnt_ff == 1)
			hold_ff <= 2'h2;
		else if (hold_ff != 2'h0)
			hold_ff <= hold_ff - 2'h1;
	end

	always_comb
	begin
		o_dev_flag       = '0;
		o_dev_flag[CODE] = (hold_ff != 2'h0);
	end
endmodule : scpi_dev_model
`default_nettype wire

// ### dv/test_select_code_priority_interrupt.sv
// self-checking bench of the select-code priority interrupt block
`timescale 1ns/100ps
`default_nettype none
`include "scpi_consts.svh"
module test_select_code_priority_interrupt;
	localparam logic [7:0] HALT = 8'h40, STEP = 8'h20, RUN = 8'h10, INDJ = 8'h08;
	localparam logic [7:0] INDP = 8'h04, DONE = 8'h02, DMA = 8'h01;
	logic                clk;
	logic                srst;
	logic                ce;
	logic                errp;
	logic [1:0]          dma_done;
	logic                preset;
	scpi_pkg::scpi_cpu_t cpu;
	scpi_pkg::scpi_io_t  io;
	logic [63:8]         dev_flag;
	logic                pwr_fail;
	logic                mux_v;
	logic [5:0]          mux_code;
	logic                mem_err;
	logic [7:0]          ra;
	logic [31:0]         wd;
	logic                wr_s;
	logic                rd_s;
	logic [31:0]         rdata;
	logic                take;
	logic [14:0]         mar;
	logic [15:0]         io_rd;
	logic [1:0]          dma_init;
	logic                req_v;
	logic [5:0]          req_code;
	int                  n_fail;
	int                  check_count;
	int                  i;

	scpi_core dut (.i_clk_sys(clk), .i_srst(srst), .i_ce(ce), .i_preset(preset),
		.i_cpu(cpu), .i_io(io), .i_dev_flag(dev_flag), .i_pwr_fail(pwr_fail),
		.i_mux_valid(mux_v), .i_mux_code(mux_code), .i_mem_err(mem_err),
		.i_err_parity(errp), .i_err_addr(15'h1234), .i_dma_done(dma_done), .i_reg_addr(ra),
		.i_reg_wdata(wd), .i_reg_wr(wr_s), .i_reg_rd(rd_s), .o_reg_rdata(rdata),
		.o_int_take(take), .o_mar(mar), .o_io_rdata(io_rd), .o_dma_init(dma_init),
		.o_req_valid(req_v), .o_req_code(req_code));

	scpi_dev_model #(.CODE(6'h09), .DLY(5)) partner (.i_clk_sys(clk), .i_srst(srst),
		.i_io(io), .o_dev_flag(dev_flag));

	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic wrap_up();
		if (n_fail == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : wrap_up

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		ra <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		@(negedge clk);
		chk(rdata, exp);
	endtask : rd

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr_s <= 1'b1;
		@(posedge clk);
		wr_s <= 1'b0;
	endtask : wr

	// results of an op are settled at the negedge this leaves us on
	task automatic op(input scpi_pkg::scpi_op_t o, input logic [5:0] s);
		@(posedge clk);
		io <= '{valid: 1'b1, op: o, sel: s};
		@(posedge clk);
		io <= '0;
		@(negedge clk);
	endtask : op

	task automatic phase(input logic t, input logic [5:0] c);
		@(posedge clk);
		cpu.phase_end <= 1'b1;
		@(negedge clk);
		chk(take, t);
		@(posedge clk);
		cpu.phase_end <= 1'b0;
		@(negedge clk);
		if (t)
			chk(mar, {9'h0, c});
	endtask : phase

	task automatic bump(input logic [7:0] m);
		@(posedge clk);
		cpu <= scpi_pkg::scpi_cpu_t'(cpu | m);
		@(posedge clk);
		cpu <= scpi_pkg::scpi_cpu_t'(cpu & ~m);
	endtask : bump

	task automatic blk(input logic [7:0] m);
		@(posedge clk);
		cpu <= scpi_pkg::scpi_cpu_t'(cpu | m);
		phase(1'b0, 6'h00);
		@(posedge clk);
		cpu <= scpi_pkg::scpi_cpu_t'(cpu & ~m);
	endtask : blk

	// vector instruction completes, then its tail phase passes
	task automatic reopen();
		bump(DONE);
		phase(1'b0, 6'h00);
	endtask : reopen

	task automatic press(input logic r);
		@(posedge clk);
		cpu.running <= r;
		preset <= 1'b1;
		repeat (4) @(posedge clk);
		preset <= 1'b0;
		repeat (3) @(posedge clk);
		cpu.running <= 1'b0;
	endtask : press

	initial
	begin
		srst = 1'b1;
		preset = 1'b0;
		cpu = '0;
		io = '0;
		pwr_fail = 1'b0;
		mux_v = 1'b0;
		mux_code = 6'h00;
		mem_err = 1'b0;
		ce = 1'b1;
		errp = 1'b1;
		dma_done = 2'h0;
		ra = 8'h00;
		wd = 32'h0;
		wr_s = 1'b0;
		rd_s = 1'b0;
		n_fail = 0;
		check_count = 0;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(`SCPI_REG_CTRL, 32'h0);
		rd(`SCPI_REG_FLAG_LO, 32'hFFFFFFFF);
		rd(`SCPI_REG_FLAG_HI, 32'hFFFFFFFF);
		rd(`SCPI_REG_CTL_HI, 32'h0);
		rd(8'h1C, 32'h0);
		chk(req_v, 1'b0);
		wr(`SCPI_REG_CTRL, 32'h1);
		op(scpi_pkg::SCPI_OP_CLR_FLG, `SCPI_SC_IEN);
		rd(`SCPI_REG_CTRL, 32'h0);
		op(scpi_pkg::SCPI_OP_SET_FLG, `SCPI_SC_IEN);
		rd(`SCPI_REG_CTRL, 32'h1);
		op(scpi_pkg::SCPI_OP_SET_CTL, 6'h01);
		op(scpi_pkg::SCPI_OP_SET_CTL, `SCPI_SC_DMA2_INIT);
		chk(dma_init, 2'h2);
		op(scpi_pkg::SCPI_OP_SET_CTL, `SCPI_SC_DMA1_INIT);
		chk(dma_init, 2'h1);
		chk(req_v, 1'b0);
		op(scpi_pkg::SCPI_OP_SET_CTL, 6'h0A);
		op(scpi_pkg::SCPI_OP_SET_CTL, 6'h08);
		chk({req_v, req_code}, {1'b1, 6'h08});
		op(scpi_pkg::SCPI_OP_CLR_FLG, 6'h08);
		chk({req_v, req_code}, {1'b1, 6'h0A});
		rd(`SCPI_REG_CTL_LO, 32'h00000500);
		phase(1'b0, 6'h00);
		wr(`SCPI_REG_CTRL, 32'h0);
		phase(1'b0, 6'h00);
		wr(`SCPI_REG_CTRL, 32'h1);
		blk(HALT);
		blk(STEP);
		blk(DMA);
		blk(INDJ);
		phase(1'b0, 6'h00);
		reopen();
		phase(1'b1, 6'h0A);
		op(scpi_pkg::SCPI_OP_LOAD_IN, `SCPI_SC_PWRF);
		chk(io_rd, 16'h000A);
		phase(1'b0, 6'h00);
		reopen();
		phase(1'b1, 6'h0A);
		bump(INDP);
		phase(1'b0, 6'h00);
		bump(INDP);
		phase(1'b1, 6'h0A);
		reopen();
		op(scpi_pkg::SCPI_OP_CLR_FLG, `SCPI_SC_PWRF);
		@(posedge clk);
		pwr_fail <= 1'b1;
		repeat (3) @(posedge clk);
		pwr_fail <= 1'b0;
		rd(`SCPI_REG_FLAG_LO, 32'hFFFFFEFF);
		op(scpi_pkg::SCPI_OP_CLR_FLG, `SCPI_SC_DMA1);
		op(scpi_pkg::SCPI_OP_CLR_FLG, `SCPI_SC_DMA2);
		rd(`SCPI_REG_FLAG_LO, 32'hFFFFFE3F);
		@(posedge clk);
		dma_done <= 2'h2;
		@(posedge clk);
		dma_done <= 2'h0;
		rd(`SCPI_REG_FLAG_LO, 32'hFFFFFEBF);
		op(scpi_pkg::SCPI_OP_SET_CTL, `SCPI_SC_PWRF);
		@(posedge clk);
		cpu <= scpi_pkg::scpi_cpu_t'(cpu | DMA);
		phase(1'b0, 6'h00);
		phase(1'b1, `SCPI_SC_PWRF);
		@(posedge clk);
		cpu <= scpi_pkg::scpi_cpu_t'(cpu & ~DMA);
		reopen();
		op(scpi_pkg::SCPI_OP_LOAD_IN, `SCPI_SC_PWRF);
		chk(io_rd, 16'h0004);
		op(scpi_pkg::SCPI_OP_CLR_CTL, `SCPI_SC_PWRF);
		@(posedge clk);
		mem_err <= 1'b1;
		@(posedge clk);
		mem_err <= 1'b0;
		op(scpi_pkg::SCPI_OP_LOAD_IN, `SCPI_SC_MERR);
		chk(io_rd, 16'h9234);
		rd(`SCPI_REG_ERR, 32'h00009234);
		@(posedge clk);
		errp <= 1'b0;
		mem_err <= 1'b1;
		@(posedge clk);
		mem_err <= 1'b0;
		op(scpi_pkg::SCPI_OP_LOAD_IN, `SCPI_SC_MERR);
		chk(io_rd, 16'h1234);
		op(scpi_pkg::SCPI_OP_CLR_CTL, 6'h0A);
		chk(req_v, 1'b0);
		op(scpi_pkg::SCPI_OP_CLR_FLG, 6'h09);
		op(scpi_pkg::SCPI_OP_SET_CTL, 6'h09);
		for (i = 0; i < 40 && req_v !== 1'b1; i++)
			@(negedge clk);
		if (req_v !== 1'b1)
		begin
			n_fail++;
			wrap_up();
		end
		repeat (10) @(negedge clk);
		chk({req_v, req_code}, {1'b1, 6'h09});
		// clock enable low: the clear must be ignored
		@(posedge clk);
		ce <= 1'b0;
		op(scpi_pkg::SCPI_OP_CLR_FLG, 6'h09);
		@(posedge clk);
		ce <= 1'b1;
		@(negedge clk);
		chk({req_v, req_code}, {1'b1, 6'h09});
		op(scpi_pkg::SCPI_OP_CLR_FLG, 6'h30);
		rd(`SCPI_REG_FLAG_HI, 32'hFFFEFFFF);
		@(posedge clk);
		mux_code <= 6'h30;
		mux_v <= 1'b1;
		repeat (3) @(posedge clk);
		mux_v <= 1'b0;
		rd(`SCPI_REG_FLAG_HI, 32'hFFFFFFFF);
		press(1'b1);
		rd(`SCPI_REG_CTRL, 32'h1);
		press(1'b0);
		rd(`SCPI_REG_CTRL, 32'h0);
		rd(`SCPI_REG_FLAG_LO, 32'hFFFFFFFF);
		rd(`SCPI_REG_CTL_LO, 32'h0);
		rd(`SCPI_REG_STATUS, 32'h00000480);
		wrap_up();
	end
endmodule : test_select_code_priority_interrupt
`default_nettype wire
